/* logic/cms_pkg.sv */
`default_nettype none
package cms_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_NODE   = 8'h04;
  localparam logic [7:0] ADR_TASK   = 8'h08;
  localparam logic [7:0] ADR_MULT   = 8'h0c;
  localparam logic [7:0] ADR_TXDLY  = 8'h10;
  localparam logic [7:0] ADR_SHIFT  = 8'h14;
  localparam logic [7:0] ADR_HOST   = 8'h18;
  localparam logic [7:0] ADR_HBPER  = 8'h1c;
  localparam logic [7:0] ADR_STAT   = 8'h20;
  localparam logic [7:0] ADR_CCOPY  = 8'h24;
  localparam logic [7:0] ADR_HBID   = 8'h28;
  localparam logic [7:0] ADR_EXPIDX = 8'h2c;
  localparam logic [7:0] ADR_EXPDAT = 8'h30;
  localparam logic [7:0] ADR_RESULT = 8'h34;
  localparam logic [7:0] ADR_LASTRX = 8'h38;
  // Control bit positions
  localparam int CTL_RUN    = 0;
  localparam int CTL_RESET  = 1;
  localparam int CTL_SCAN   = 2;
  localparam int CTL_VERIFY = 3;
  localparam int CTL_CONFIG = 4;
  localparam int CTL_OPER   = 5;
  localparam int CTL_MEAS   = 6;
  // Reset values
  localparam logic [6:0]  NODE_RST  = 7'h01;
  localparam logic [31:0] TASK_RST  = 32'h0026_25a0;
  localparam logic [7:0]  MULT_RST  = 8'h01;
  localparam logic [6:0]  TXDLY_RST = 7'h00;
  localparam logic [6:0]  SHIFT_RST = 7'h50;
  localparam logic [31:0] HOST_RST  = 32'h0026_25a0;
  localparam logic [31:0] HBPER_RST = 32'h0026_25a0;
  // Limits
  localparam logic [6:0]  NODE_MIN  = 7'h01;
  localparam logic [6:0]  NODE_MAX  = 7'h7f;
  localparam logic [6:0]  PCT_MAX   = 7'h64;
  localparam logic [7:0]  MULT_MIN  = 8'h01;
  // Identifier bases
  localparam logic [10:0] COB_NMT   = 11'h000;
  localparam logic [10:0] COB_SYNC  = 11'h080;
  localparam logic [10:0] COB_SDO   = 11'h600;
  localparam logic [10:0] COB_HB    = 11'h700;

  typedef enum logic [2:0] {
    KIND_NMT_RESET = 3'h0,
    KIND_SYNC      = 3'h1,
    KIND_HEARTBEAT = 3'h2,
    KIND_READ_ID   = 3'h3,
    KIND_READ_PDO  = 3'h4
  } cms_kind_e;

  typedef enum logic [2:0] {
    SC_IDLE     = 3'b000,
    SC_ID_REQ   = 3'b001,
    SC_ID_WAIT  = 3'b011,
    SC_PDO_REQ  = 3'b010,
    SC_PDO_WAIT = 3'b110,
    SC_NEXT     = 3'b111
  } cms_scan_e;

  typedef struct packed {
    cms_kind_e   kind;
    logic [6:0]  node;
    logic [10:0] cobid;
  } cms_txreq_s;

  typedef struct packed {
    logic        present;
    logic [31:0] data;
  } cms_rx_s;
endpackage
`default_nettype wire

/* logic/cms_pct_scale.sv */
`timescale 1ns/1ps
`default_nettype none
// Percentage of a period in whole ticks, registered
module cms_pct_scale import cms_pkg::*; #(
  parameter int PW = 32
) (
  input  wire logic          clk,    // Clock
  input  wire logic          rst_n,  // Async reset, low active
  input  wire logic [6:0]    pct,    // Percent 0..100
  input  wire logic [PW-1:0] period, // Period in ticks
  output logic      [PW-1:0] ticks   // Truncated result
);
  typedef struct packed {
    logic [PW-1:0] ticks;
  } cms_scl_s;

  cms_scl_s r_ff, nxt_r;
  logic [PW+6:0] prod;

  // Truncating divide keeps the result at or below the exact fraction
  always_comb begin
    nxt_r = r_ff;
    prod  = {7'h00, period} * {{PW{1'b0}}, pct};
    nxt_r.ticks = PW'(prod / (PW+7)'(PCT_MAX));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign ticks = r_ff.ticks;
endmodule
`default_nettype wire

/* logic/cms_sync_sched.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Master node number 1..127 sets the heartbeat identifier.
// - SYNC period equals task cycle times SYNC multiplier.
// - With multiplier above one, several task cycles run between SYNCs.
// - Own synchronous output PDOs wait a percentage of the SYNC period.
// - Host inputs update at a set percentage of each host cycle.
// - In operational state a measure request records the calc-copy time.
// - An online reset request sends a reset to all bus nodes.
// - Scan in config mode finds nodes, reads PDO setup and identity.
// - Verify in config mode compares each identity with the expected one.
module cms_sync_sched import cms_pkg::*; (
  input  wire logic        CLK,          // 250 MHz clock
  input  wire logic        RSTN,         // Async reset, low active
  input  wire logic        WB_CYC_I,     // Wishbone cycle
  input  wire logic        WB_STB_I,     // Wishbone strobe
  input  wire logic        WB_WE_I,      // Wishbone write enable
  input  wire logic [7:0]  WB_ADR_I,     // Wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,     // Wishbone byte lanes
  input  wire logic [31:0] WB_DAT_I,     // Wishbone write data
  output logic      [31:0] WB_DAT_O,     // Wishbone read data
  output logic             WB_ACK_O,     // Wishbone acknowledge
  output logic             TX_VALID,     // Frame request to CAN controller
  output var cms_txreq_s   TX_REQ,       // Frame kind, node, identifier
  input  wire logic        TX_ACK,       // Controller took the request
  input  wire logic        RX_VALID,     // Answer to a read request
  input  wire cms_rx_s     RX_ANS,       // Presence and read data
  input  wire logic        HOST_SOF,     // Host fieldbus cycle start
  input  wire logic        COPY_DONE,    // Calc-and-copy finished
  output logic             TASK_TICK,    // Task cycle start pulse
  output logic             PDO_RELEASE,  // Send own synchronous PDOs
  output logic             INPUT_UPDATE  // Update host inputs now
);
  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
    logic [6:0]  ctrl;
    logic [6:0]  node;
    logic [31:0] task_cyc;
    logic [7:0]  mult;
    logic [6:0]  txdly;
    logic [6:0]  shift;
    logic [31:0] host_cyc;
    logic [31:0] hb_per;
    logic [6:0]  exp_idx;
    logic [31:0] task_cnt;
    logic [7:0]  sync_cnt;
    logic [31:0] dly_cnt;
    logic        dly_run;
    logic [31:0] host_cnt;
    logic        host_run;
    logic [31:0] hb_cnt;
    logic        meas_arm;
    logic        meas_run;
    logic [31:0] meas_cnt;
    logic [31:0] ccopy;
    logic        nmt_pend;
    logic        sync_pend;
    logic        hb_pend;
    cms_scan_e   scan;
    logic        verify;
    logic [6:0]  scan_node;
    logic [7:0]  found;
    logic [7:0]  mism;
    logic [6:0]  first_mism;
    logic [31:0] last_rx;
    logic        tx_valid;
    cms_txreq_s  tx;
    logic        task_tick;
    logic        pdo_rel;
    logic        in_upd;
  } cms_state_s;

  cms_state_s  r_ff, nxt_r;
  logic [31:0] exp_mem [128];
  logic [31:0] sync_per, dly_ticks, shift_ticks;
  logic        wr, rd_exp_wr;

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Counter wrap test shared by all timers
  function automatic logic hit(input logic [31:0] cnt, input logic [31:0] lim);
    return (lim == 32'h0) || (cnt >= lim - 32'h1);
  endfunction

  assign sync_per = 32'(r_ff.task_cyc * {24'h0, r_ff.mult});
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !r_ff.ack;
  assign rd_exp_wr = wr && (WB_ADR_I == ADR_EXPDAT);

  cms_pct_scale #(.PW(32)) u_dly (
    .clk    (CLK),
    .rst_n  (RSTN),
    .pct    (r_ff.txdly),
    .period (sync_per),
    .ticks  (dly_ticks)
  );

  cms_pct_scale #(.PW(32)) u_shift (
    .clk    (CLK),
    .rst_n  (RSTN),
    .pct    (r_ff.shift),
    .period (r_ff.host_cyc),
    .ticks  (shift_ticks)
  );

  always_comb begin
    logic [31:0] w;
    logic        sync_now;
    nxt_r     = r_ff;
    w         = 32'h0;
    sync_now  = 1'b0;
    nxt_r.task_tick = 1'b0;
    nxt_r.pdo_rel   = 1'b0;
    nxt_r.in_upd    = 1'b0;
    nxt_r.ctrl[CTL_RESET]  = 1'b0;
    nxt_r.ctrl[CTL_SCAN]   = 1'b0;
    nxt_r.ctrl[CTL_VERIFY] = 1'b0;

    // Bus slave: one wait-free answer on the edge after the request
    nxt_r.ack = WB_CYC_I && WB_STB_I && !r_ff.ack;
    nxt_r.dat = 32'h0;
    if (WB_CYC_I && WB_STB_I && !r_ff.ack && !WB_WE_I) begin
      unique case (WB_ADR_I)
        ADR_CTRL:   nxt_r.dat = {25'h0, r_ff.ctrl};
        ADR_NODE:   nxt_r.dat = {25'h0, r_ff.node};
        ADR_TASK:   nxt_r.dat = r_ff.task_cyc;
        ADR_MULT:   nxt_r.dat = {24'h0, r_ff.mult};
        ADR_TXDLY:  nxt_r.dat = {25'h0, r_ff.txdly};
        ADR_SHIFT:  nxt_r.dat = {25'h0, r_ff.shift};
        ADR_HOST:   nxt_r.dat = r_ff.host_cyc;
        ADR_HBPER:  nxt_r.dat = r_ff.hb_per;
        ADR_STAT:   nxt_r.dat = {24'h0, r_ff.meas_arm, r_ff.verify, r_ff.nmt_pend,
                                 r_ff.tx_valid, 1'b0, r_ff.scan};
        ADR_CCOPY:  nxt_r.dat = r_ff.ccopy;
        ADR_HBID:   nxt_r.dat = {21'h0, COB_HB | {4'h0, r_ff.node}};
        ADR_EXPIDX: nxt_r.dat = {25'h0, r_ff.exp_idx};
        ADR_EXPDAT: nxt_r.dat = exp_mem[r_ff.exp_idx];
        ADR_RESULT: nxt_r.dat = {9'h0, r_ff.first_mism, r_ff.mism, r_ff.found};
        ADR_LASTRX: nxt_r.dat = r_ff.last_rx;
        default:    nxt_r.dat = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (WB_ADR_I)
        ADR_CTRL: begin
          w = merge({25'h0, r_ff.ctrl}, WB_DAT_I, WB_SEL_I);
          nxt_r.ctrl = w[6:0];
          if (w[CTL_MEAS] && r_ff.ctrl[CTL_OPER]) begin
            nxt_r.meas_arm = 1'b1;
          end
          nxt_r.ctrl[CTL_MEAS] = 1'b0;
        end
        ADR_NODE: begin
          w = merge({25'h0, r_ff.node}, WB_DAT_I, WB_SEL_I);
          if (w[31:7] == 25'h0 && w[6:0] >= NODE_MIN) begin
            nxt_r.node = w[6:0];
          end
        end
        ADR_TASK:  nxt_r.task_cyc = merge(r_ff.task_cyc, WB_DAT_I, WB_SEL_I);
        ADR_MULT: begin
          w = merge({24'h0, r_ff.mult}, WB_DAT_I, WB_SEL_I);
          nxt_r.mult = (w[7:0] < MULT_MIN) ? MULT_MIN : w[7:0];
        end
        ADR_TXDLY: begin
          w = merge({25'h0, r_ff.txdly}, WB_DAT_I, WB_SEL_I);
          nxt_r.txdly = (w[6:0] > PCT_MAX) ? PCT_MAX : w[6:0];
        end
        ADR_SHIFT: begin
          w = merge({25'h0, r_ff.shift}, WB_DAT_I, WB_SEL_I);
          nxt_r.shift = (w[6:0] > PCT_MAX) ? PCT_MAX : w[6:0];
        end
        ADR_HOST:   nxt_r.host_cyc = merge(r_ff.host_cyc, WB_DAT_I, WB_SEL_I);
        ADR_HBPER:  nxt_r.hb_per = merge(r_ff.hb_per, WB_DAT_I, WB_SEL_I);
        ADR_EXPIDX: begin
          w = merge({25'h0, r_ff.exp_idx}, WB_DAT_I, WB_SEL_I);
          nxt_r.exp_idx = w[6:0];
        end
        default: ;
      endcase
    end

    // Task cycle and SYNC divider; a new SYNC restarts the PDO hold-off
    if (r_ff.ctrl[CTL_RUN]) begin
      nxt_r.task_cnt = r_ff.task_cnt + 32'h1;
      if (hit(r_ff.task_cnt, r_ff.task_cyc)) begin
        nxt_r.task_cnt  = 32'h0;
        nxt_r.task_tick = 1'b1;
        nxt_r.sync_cnt  = r_ff.sync_cnt + 8'h1;
        if (hit({24'h0, r_ff.sync_cnt}, {24'h0, r_ff.mult})) begin
          nxt_r.sync_cnt = 8'h0;
          sync_now       = 1'b1;
        end
      end
    end else begin
      nxt_r.task_cnt = 32'h0;
      nxt_r.sync_cnt = 8'h0;
    end

    // Own PDOs leave only after the hold-off, slaves answer first
    if (r_ff.dly_run) begin
      nxt_r.dly_cnt = r_ff.dly_cnt + 32'h1;
      if (hit(r_ff.dly_cnt, dly_ticks) || dly_ticks == 32'h0) begin
        nxt_r.dly_run = 1'b0;
        nxt_r.pdo_rel = 1'b1;
      end
    end
    if (sync_now) begin
      nxt_r.dly_run = 1'b1;
      nxt_r.dly_cnt = 32'h0;
    end

    // Input update point inside the host cycle; spacing to next cycle is host's job
    if (r_ff.host_run) begin
      nxt_r.host_cnt = r_ff.host_cnt + 32'h1;
      if (hit(r_ff.host_cnt, shift_ticks) || shift_ticks == 32'h0) begin
        nxt_r.host_run = 1'b0;
        nxt_r.in_upd   = 1'b1;
      end
    end
    if (HOST_SOF) begin
      nxt_r.host_run = 1'b1;
      nxt_r.host_cnt = 32'h0;
    end

    // Calc-and-copy stopwatch from input update to copy done
    if (r_ff.meas_run) begin
      nxt_r.meas_cnt = r_ff.meas_cnt + 32'h1;
      if (COPY_DONE) begin
        nxt_r.meas_run = 1'b0;
        nxt_r.ccopy    = r_ff.meas_cnt + 32'h1;
      end
    end else if (r_ff.meas_arm && r_ff.in_upd && r_ff.ctrl[CTL_OPER]) begin
      // A new request in the same cycle re-arms, so the set wins over the clear
      nxt_r.meas_arm = wr && (WB_ADR_I == ADR_CTRL) && w[CTL_MEAS];
      nxt_r.meas_run = 1'b1;
      nxt_r.meas_cnt = 32'h0;
    end

    // Heartbeat timer
    if (r_ff.ctrl[CTL_RUN]) begin
      nxt_r.hb_cnt = r_ff.hb_cnt + 32'h1;
      if (hit(r_ff.hb_cnt, r_ff.hb_per)) begin
        nxt_r.hb_cnt = 32'h0;
      end
    end else begin
      nxt_r.hb_cnt = 32'h0;
    end

    // Scan and verify walk over node numbers, own number skipped
    unique case (r_ff.scan)
      SC_IDLE: begin
        if (r_ff.ctrl[CTL_CONFIG] && (r_ff.ctrl[CTL_SCAN] || r_ff.ctrl[CTL_VERIFY])) begin
          nxt_r.verify     = r_ff.ctrl[CTL_VERIFY];
          nxt_r.scan_node  = NODE_MIN;
          nxt_r.found      = 8'h0;
          nxt_r.mism       = 8'h0;
          nxt_r.first_mism = 7'h0;
          nxt_r.scan       = (r_ff.node == NODE_MIN) ? SC_NEXT : SC_ID_REQ;
        end
      end
      SC_ID_REQ:  ;
      SC_PDO_REQ: ;
      SC_ID_WAIT: begin
        if (RX_VALID) begin
          nxt_r.last_rx = RX_ANS.data;
          nxt_r.scan    = SC_NEXT;
          if (RX_ANS.present) begin
            nxt_r.found = r_ff.found + 8'h1;
            if (r_ff.verify && RX_ANS.data != exp_mem[r_ff.scan_node]) begin
              nxt_r.mism = r_ff.mism + 8'h1;
              if (r_ff.mism == 8'h0) begin
                nxt_r.first_mism = r_ff.scan_node;
              end
            end
            if (!r_ff.verify) begin
              nxt_r.scan = SC_PDO_REQ;
            end
          end
        end
      end
      SC_PDO_WAIT: begin
        if (RX_VALID) begin
          nxt_r.last_rx = RX_ANS.data;
          nxt_r.scan    = SC_NEXT;
        end
      end
      SC_NEXT: begin
        nxt_r.scan_node = r_ff.scan_node + 7'h1;
        nxt_r.scan      = SC_ID_REQ;
        if (r_ff.scan_node == NODE_MAX) begin
          nxt_r.scan = SC_IDLE;
        end else if (r_ff.scan_node + 7'h1 == r_ff.node) begin
          nxt_r.scan = SC_NEXT;
        end
      end
      // Unused codes fall back to idle
      default: nxt_r.scan = SC_IDLE;
    endcase

    // Single outstanding frame request, reset before SYNC before heartbeat before reads
    if (r_ff.tx_valid && TX_ACK) begin
      nxt_r.tx_valid = 1'b0;
    end else if (!r_ff.tx_valid) begin
      if (r_ff.nmt_pend) begin
        nxt_r.nmt_pend = 1'b0;
        nxt_r.tx_valid = 1'b1;
        nxt_r.tx       = '{KIND_NMT_RESET, 7'h0, COB_NMT};
      end else if (r_ff.sync_pend) begin
        nxt_r.sync_pend = 1'b0;
        nxt_r.tx_valid  = 1'b1;
        nxt_r.tx        = '{KIND_SYNC, 7'h0, COB_SYNC};
      end else if (r_ff.hb_pend) begin
        nxt_r.hb_pend  = 1'b0;
        nxt_r.tx_valid = 1'b1;
        nxt_r.tx       = '{KIND_HEARTBEAT, r_ff.node, COB_HB | {4'h0, r_ff.node}};
      end else if (r_ff.scan == SC_ID_REQ || r_ff.scan == SC_PDO_REQ) begin
        nxt_r.tx_valid = 1'b1;
        nxt_r.tx       = '{(r_ff.scan == SC_ID_REQ) ? KIND_READ_ID : KIND_READ_PDO,
                          r_ff.scan_node, COB_SDO | {4'h0, r_ff.scan_node}};
        nxt_r.scan     = (r_ff.scan == SC_ID_REQ) ? SC_ID_WAIT : SC_PDO_WAIT;
      end
    end

    // New events set after the clears so a same-cycle event is kept
    if (r_ff.ctrl[CTL_RESET]) begin
      nxt_r.nmt_pend = 1'b1;
    end
    if (sync_now) begin
      nxt_r.sync_pend = 1'b1;
    end
    if (r_ff.ctrl[CTL_RUN] && hit(r_ff.hb_cnt, r_ff.hb_per)) begin
      nxt_r.hb_pend = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      r_ff          <= '0;
      r_ff.node     <= NODE_RST;
      r_ff.task_cyc <= TASK_RST;
      r_ff.mult     <= MULT_RST;
      r_ff.txdly    <= TXDLY_RST;
      r_ff.shift    <= SHIFT_RST;
      r_ff.host_cyc <= HOST_RST;
      r_ff.hb_per   <= HBPER_RST;
      r_ff.scan     <= SC_IDLE;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Expected identities; memory has no reset, software loads it before verify
  always_ff @(posedge CLK) begin
    if (rd_exp_wr) begin
      exp_mem[r_ff.exp_idx] <= merge(exp_mem[r_ff.exp_idx], WB_DAT_I, WB_SEL_I);
    end
  end

  assign WB_DAT_O     = r_ff.dat;
  assign WB_ACK_O     = r_ff.ack;
  assign TX_VALID     = r_ff.tx_valid;
  assign TX_REQ       = r_ff.tx;
  assign TASK_TICK    = r_ff.task_tick;
  assign PDO_RELEASE  = r_ff.pdo_rel;
  assign INPUT_UPDATE = r_ff.in_upd;
endmodule
`default_nettype wire

/* tb/cms_sync_sched_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the bus and frame-request ports of the scheduler
module cms_sync_sched_sva import cms_pkg::*; (
  input wire logic        CLK,      // Clock
  input wire logic        RSTN,     // Async reset, low active
  input wire logic        WB_CYC_I, // Bus cycle
  input wire logic        WB_STB_I, // Bus strobe
  input wire logic [31:0] WB_DAT_O, // Read data
  input wire logic        WB_ACK_O, // Acknowledge
  input wire logic        TX_VALID, // Frame request
  input wire cms_txreq_s  TX_REQ,   // Frame contents
  input wire logic        TX_ACK    // Request taken
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Bus: answer one edge after the take, a single pulse, data quiet otherwise
  property p_ack_take; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack_take: assert property (p_ack_take) else $error("no ack after take");
  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat_quiet; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside ack");
  // Frame request holds still until taken, then falls
  property p_tx_hold; TX_VALID && !TX_ACK |=> TX_VALID && $stable(TX_REQ); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("request changed early");
  property p_tx_drop; TX_VALID && TX_ACK |=> !TX_VALID; endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("request kept after take");
  // Identifier of each frame kind
  property p_sync_id; TX_VALID && TX_REQ.kind == KIND_SYNC |-> TX_REQ.cobid == COB_SYNC;
  endproperty
  a_sync_id: assert property (p_sync_id) else $error("bad sync id");
  property p_hb_id;
    TX_VALID && TX_REQ.kind == KIND_HEARTBEAT |-> TX_REQ.node != 7'h00 &&
      TX_REQ.cobid == COB_HB + {4'h0, TX_REQ.node};
  endproperty
  a_hb_id: assert property (p_hb_id) else $error("bad heartbeat id");
  property p_nmt_id; TX_VALID && TX_REQ.kind == KIND_NMT_RESET |-> TX_REQ.cobid == COB_NMT;
  endproperty
  a_nmt_id: assert property (p_nmt_id) else $error("bad reset id");
  property p_read_id;
    TX_VALID && (TX_REQ.kind == KIND_READ_ID || TX_REQ.kind == KIND_READ_PDO) |->
      TX_REQ.node != 7'h00 && TX_REQ.cobid == COB_SDO + {4'h0, TX_REQ.node};
  endproperty
  a_read_id: assert property (p_read_id) else $error("bad read id");
  c_sync: cover property (TX_VALID && TX_ACK && TX_REQ.kind == KIND_SYNC);
  c_nmt: cover property (TX_VALID && TX_ACK && TX_REQ.kind == KIND_NMT_RESET);
  c_pdo: cover property (TX_VALID && TX_ACK && TX_REQ.kind == KIND_READ_PDO);
endmodule
bind cms_sync_sched cms_sync_sched_sva i_sva (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TX_VALID(TX_VALID),
  .TX_REQ(TX_REQ), .TX_ACK(TX_ACK));
`default_nettype wire

/* tb/cms_can_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural CAN controller plus slaves: only nodes 2 and 3 exist
module cms_can_partner import cms_pkg::*; (
  input  wire logic       clk,      // Clock
  input  wire logic       rst_n,    // Async reset, low active
  input  wire logic       slow,     // Stall each take by three cycles
  input  wire logic       tx_valid, // Frame request
  input  wire cms_txreq_s tx_req,   // Frame contents
  output logic            tx_ack,   // Request taken
  output logic            rx_valid, // Read answer strobe
  output var cms_rx_s     rx_ans    // Read answer
);
  logic [1:0] wait_q;
  logic [2:0] ans_q;
  logic [6:0] node_q;
  // Take requests, then answer reads two cycles later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ack <= 1'b0;
      rx_valid <= 1'b0;
      rx_ans <= '0;
      wait_q <= 2'h0;
      ans_q <= 3'h0;
      node_q <= 7'h00;
    end else begin
      tx_ack <= 1'b0;
      rx_valid <= 1'b0;
      // Synchronous slaves answer a SYNC at once; only the take is modelled
      if (tx_valid && !tx_ack) begin
        if (slow && wait_q != 2'h3) begin
          wait_q <= wait_q + 2'h1;
        end else begin
          tx_ack <= 1'b1;
          wait_q <= 2'h0;
          if (tx_req.kind == KIND_READ_ID || tx_req.kind == KIND_READ_PDO) begin
            ans_q <= 3'h2;
            node_q <= tx_req.node;
          end
        end
      end
      if (ans_q != 3'h0) begin
        ans_q <= ans_q - 3'h1;
      end
      // Answer once; in between the bus shows garbage, so it is never stable
      if (ans_q == 3'h1) begin
        rx_valid <= 1'b1;
        rx_ans <= '{(node_q == 7'h02 || node_q == 7'h03), {16'h0cad, 9'h0, node_q}};
      end else begin
        rx_ans <= ~rx_ans;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/cms_sync_sched_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cms_sync_sched_tb import cms_pkg::*; ;
  logic clk, rst_n, cyc, stb, we, ack, tx_valid, tx_ack, rx_valid, host_sof, copy_done;
  logic task_tick, pdo_rel, in_upd, slow;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  cms_txreq_s tx_req;
  cms_rx_s rx_ans;
  int bad_count, checks;
  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  cms_sync_sched i_dut (.CLK(clk), .RSTN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .TX_VALID(tx_valid), .TX_REQ(tx_req), .TX_ACK(tx_ack), .RX_VALID(rx_valid),
    .RX_ANS(rx_ans), .HOST_SOF(host_sof), .COPY_DONE(copy_done), .TASK_TICK(task_tick),
    .PDO_RELEASE(pdo_rel), .INPUT_UPDATE(in_upd));
  cms_can_partner i_can (.clk(clk), .rst_n(rst_n), .slow(slow), .tx_valid(tx_valid),
    .tx_req(tx_req), .tx_ack(tx_ack), .rx_valid(rx_valid), .rx_ans(rx_ans));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tmo();
    bad_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    finish_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; entered just after a rising edge, leaves one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) tmo();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask
  // Reset values, clamping and refused writes, heartbeat identifier
  task automatic t_regs();
    rdc(ADR_NODE, 32'(NODE_RST));
    rdc(ADR_SHIFT, 32'(SHIFT_RST));
    rdc(ADR_HBID, 32'(COB_HB) + 32'(NODE_RST));
    wr(ADR_NODE, 32'h0);
    wr(ADR_NODE, 32'h80);
    rdc(ADR_NODE, 32'h1);
    wr(ADR_NODE, 32'h7f);
    rdc(ADR_HBID, 32'h77f);
    wr(ADR_NODE, 32'h1);
    wr(ADR_MULT, 32'h0);
    rdc(ADR_MULT, 32'(MULT_MIN));
    wr(ADR_TXDLY, 32'd101);
    rdc(ADR_TXDLY, 32'(PCT_MAX));
    wr(8'h3c, 32'h5);
    rdc(8'h3c, 32'h0);
    $display("test regs done");
  endtask
  // Task 20, multiplier 3, delay 40 percent: SYNC each 60, PDOs 24 later
  task automatic t_sync();
    int n, tk = 0, s0 = -1, s1 = -1, pr = -1;
    wr(ADR_TASK, 32'd20);
    wr(ADR_MULT, 32'd3);
    wr(ADR_TXDLY, 32'd40);
    wr(ADR_CTRL, 32'h1);
    for (n = 0; n < 400 && s1 < 0; n++) begin
      @(negedge clk);
      if (task_tick === 1'b1 && s0 >= 0) tk++;
      if (pdo_rel === 1'b1 && s0 >= 0 && pr < 0) pr = n - s0;
      if (tx_valid === 1'b1 && tx_ack && tx_req.kind === KIND_SYNC) begin
        if (s0 < 0) s0 = n;
        else s1 = n;
      end
    end
    if (s1 < 0) tmo();
    chk(s1 - s0, 60);
    chk(tk, 3);
    chk(pr >= 22 && pr <= 28, 1);
    @(posedge clk);
    wr(ADR_CTRL, 32'h0);
    $display("test sync done");
  endtask
  // Host cycle 20 at 80 percent, plus calc-and-copy measurement
  task automatic t_shift();
    int n;
    logic [31:0] q;
    wr(ADR_HOST, 32'd20);
    wr(ADR_SHIFT, 32'd80);
    wr(ADR_CTRL, 32'h20);
    wr(ADR_CTRL, 32'h60);
    host_sof <= 1'b1;
    @(posedge clk);
    host_sof <= 1'b0;
    for (n = 0; n < 100 && in_upd !== 1'b1; n++) @(negedge clk);
    chk(n >= 15 && n <= 19, 1);
    repeat (4) @(posedge clk);
    copy_done <= 1'b1;
    @(posedge clk);
    copy_done <= 1'b0;
    rd(ADR_CCOPY, q);
    chk(q >= 32'd4 && q <= 32'd8, 1);
    wr(ADR_CTRL, 32'h0);
    $display("test shift done");
  endtask
  // Online reset sends the reset frame; a running master then sends its heartbeat
  task automatic t_reset();
    int n;
    wr(ADR_CTRL, 32'h2);
    for (n = 0; n < 100 && !(tx_valid && tx_req.kind === KIND_NMT_RESET); n++) @(negedge clk);
    chk(n < 100, 1);
    chk(tx_req.cobid, 32'(COB_NMT));
    @(posedge clk);
    // Short period so a heartbeat frame really leaves; node is 1 here
    wr(ADR_HBPER, 32'd30);
    wr(ADR_CTRL, 32'h1);
    for (n = 0; n < 200 && !(tx_valid === 1'b1 && tx_req.kind === KIND_HEARTBEAT); n++)
      @(negedge clk);
    chk(n < 200, 1);
    chk(tx_req.cobid, 32'(COB_HB) + 32'h1);
    @(posedge clk);
    wr(ADR_CTRL, 32'h0);
    $display("test reset done");
  endtask
  // Follows a node walk, counting reads taken
  task automatic walk(output int ids, output int pdos, output int own);
    int n;
    ids = 0;
    pdos = 0;
    own = 0;
    for (n = 0; n < 20000 && ids < 126; n++) begin
      @(negedge clk);
      if (tx_valid === 1'b1 && tx_ack) begin
        if (tx_req.kind === KIND_READ_ID) ids++;
        if (tx_req.kind === KIND_READ_PDO) pdos++;
        if (tx_req.kind === KIND_READ_ID && tx_req.node === 7'h01) own++;
      end
    end
    if (ids < 126) tmo();
    repeat (60) @(negedge clk);
    @(posedge clk);
  endtask
  // Scan with a stalling controller finds nodes 2 and 3
  task automatic t_scan();
    int ids, pdos, own;
    logic [31:0] q;
    slow <= 1'b1;
    wr(ADR_CTRL, 32'h10);
    wr(ADR_CTRL, 32'h14);
    walk(ids, pdos, own);
    chk(ids, 126);
    chk(own, 0);
    chk(pdos, 2);
    rd(ADR_RESULT, q);
    chk(q[7:0], 8'd2);
    $display("test scan done");
  endtask
  // Verify against a table that is wrong for node 3 only
  task automatic t_verify();
    int k, ids, pdos, own;
    logic [31:0] q;
    slow <= 1'b0;
    for (k = 1; k < 128; k++) begin
      wr(ADR_EXPIDX, 32'(k));
      wr(ADR_EXPDAT, (k == 3) ? 32'h0 : {16'h0cad, 9'h0, 7'(k)});
    end
    wr(ADR_CTRL, 32'h18);
    walk(ids, pdos, own);
    chk(pdos, 0);
    rd(ADR_RESULT, q);
    chk(q[22:16], 7'd3);
    chk(q[15:8], 8'd1);
    $display("test verify done");
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, host_sof, copy_done, slow} = 6'h0;
    adr = 8'h0;
    sel = 4'hf;
    wdat = 32'h0;
    bad_count = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_sync();
    t_shift();
    t_reset();
    t_scan();
    t_verify();
    finish_test();
  end
endmodule
`default_nettype wire
